// *** common/csfr_pkg.sv ***
// Package for the CPU status flag register block: offsets, fields, resets.
package csfr_pkg;
	// Register file offsets
	localparam logic [8:0] CSFR_STATUS_OFS_LO = 9'h003;
	localparam logic [8:0] CSFR_STATUS_OFS_HI = 9'h083;
	localparam logic [8:0] CSFR_OPTION_OFS = 9'h081;
	localparam logic [8:0] CSFR_PCHOLD_OFS_LO = 9'h00a;
	localparam logic [8:0] CSFR_PCHOLD_OFS_HI = 9'h08a;
	localparam logic [6:0] CSFR_SHARED_LO = 7'h70;
	// Status field positions
	localparam int CSFR_C_BIT = 0;
	localparam int CSFR_DC_BIT = 1;
	localparam int CSFR_Z_BIT = 2;
	localparam int CSFR_PD_BIT = 3;
	localparam int CSFR_TO_BIT = 4;
	localparam int CSFR_RP0_BIT = 5;
	localparam int CSFR_RP1_BIT = 6;
	localparam int CSFR_IRP_BIT = 7;
	// Option field positions
	localparam int CSFR_PSA_BIT = 3;
	// Reset values
	localparam logic [7:0] CSFR_STATUS_RST = 8'h18;
	localparam logic [7:0] CSFR_OPTION_RST = 8'hff;
	localparam logic [4:0] CSFR_PCHOLD_RST = 5'h00;
	// ALU operations that touch the flags, plus CSFR_OP_NONE that leaves them alone
	typedef enum logic [2:0] {
		CSFR_OP_NONE,
		CSFR_OP_ADD,
		CSFR_OP_SUB,
		CSFR_OP_LOGIC,
		CSFR_OP_RLF,
		CSFR_OP_RRF
	} csfr_op_t;
	// Register write request from the core
	typedef struct packed {
		logic en;
		logic [8:0] addr;
		logic [7:0] data;
	} csfr_wr_t;
	// ALU result sideband
	typedef struct packed {
		csfr_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] result;
	} csfr_alu_t;
endpackage

// *** rtl/csfr_status.sv ***
// CPU status flag register, page holding register and prescaler routing.
`timescale 1ns/100ps
`default_nettype none

module csfr_status #(
	parameter int PRESC_W = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire csfr_pkg::csfr_wr_t wr_i,
	input wire logic [8:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	output logic rd_hit_o,
	input wire csfr_pkg::csfr_alu_t alu_i,
	input wire logic por_i,
	input wire logic wdt_clear_i,
	input wire logic sleep_i,
	input wire logic wdt_timeout_i,
	input wire logic pc_load_i,
	output logic [4:0] pc_upper_o,
	output logic [1:0] bank_o,
	output logic [8:0] bank_base_o,
	input wire logic tmr_tick_i,
	input wire logic wdt_tick_i,
	output logic tmr_inc_o,
	output logic wdt_inc_o,
	output logic [7:0] option_o
);
	import csfr_pkg::*;

	// The rate field reaches prescaler bit 7, so a narrower counter fails
	if (PRESC_W < 8) begin : g_presc_w_check
		$error("PRESC_W must be at least 8");
	end

	logic [7:0] status;
	logic [2:0] alu_flags;
	logic [1:0] cause_flags;
	logic [2:0] bank_bits;
	logic [7:0] option_reg;
	logic [4:0] pc_upper_holding_reg;
	logic [PRESC_W-1:0] presc;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic flag_op;
	logic status_wr;
	logic next_z;
	logic next_dc;
	logic next_c;
	logic presc_tick;
	logic [PRESC_W-1:0] presc_mask;

	// Shared registers decode on the low seven bits, in banks 0 and 1 only
	function automatic logic shared_hit(input logic [8:0] a,
		input logic [8:0] lo);
		shared_hit = (a[6:0] == lo[6:0]) && (a[8:7] <= 2'b01);
	endfunction

	assign status_wr = wr_i.en && shared_hit(wr_i.addr, CSFR_STATUS_OFS_LO);
	assign flag_op = (alu_i.op != CSFR_OP_NONE);

	// Adder shared by add and subtract; subtract adds the complement plus one
	always_comb begin
		sum9 = 9'h000;
		sum5 = 5'h00;
		if (alu_i.op == CSFR_OP_SUB) begin
			sum9 = {1'b0, alu_i.a} + {1'b0, ~alu_i.b} + 9'h001;
			sum5 = {1'b0, alu_i.a[3:0]} + {1'b0, ~alu_i.b[3:0]} + 5'h01;
		end else begin
			sum9 = {1'b0, alu_i.a} + {1'b0, alu_i.b};
			sum5 = {1'b0, alu_i.a[3:0]} + {1'b0, alu_i.b[3:0]};
		end
	end

	// Flag values; rotates leave Z alone and only carry follows the bit out
	always_comb begin
		next_z = status[CSFR_Z_BIT];
		next_dc = status[CSFR_DC_BIT];
		next_c = status[CSFR_C_BIT];
		unique case (alu_i.op)
			CSFR_OP_NONE: begin
			end
			CSFR_OP_ADD, CSFR_OP_SUB: begin
				next_z = (alu_i.result == 8'h00);
				next_dc = sum5[4];
				next_c = sum9[8];
			end
			CSFR_OP_LOGIC: begin
				next_z = (alu_i.result == 8'h00);
			end
			CSFR_OP_RLF: begin
				next_c = alu_i.a[7];
			end
			CSFR_OP_RRF: begin
				next_c = alu_i.a[0];
			end
			default: begin
			end
		endcase
	end

	// Arithmetic flags: flag logic wins over a colliding data write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			alu_flags <= CSFR_STATUS_RST[CSFR_Z_BIT:CSFR_C_BIT];
		end else if (flag_op) begin
			alu_flags <= {next_z, next_dc, next_c};
		end else if (status_wr) begin
			alu_flags <= wr_i.data[CSFR_Z_BIT:CSFR_C_BIT];
		end
	end

	// Reset-cause flags, timeout above powerdown; writes never reach them
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cause_flags <= CSFR_STATUS_RST[CSFR_TO_BIT:CSFR_PD_BIT];
		end else if (por_i || wdt_clear_i) begin
			cause_flags <= 2'b11;
		end else if (sleep_i) begin
			cause_flags <= 2'b10;
		end else if (wdt_timeout_i) begin
			cause_flags[1] <= 1'b0;
		end
	end

	// Bank select bits; the upper one (IRP) is storable but software keeps it clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bank_bits <= CSFR_STATUS_RST[CSFR_IRP_BIT:CSFR_RP0_BIT];
		end else if (status_wr) begin
			bank_bits <= wr_i.data[CSFR_IRP_BIT:CSFR_RP0_BIT];
		end
	end

	// One owner per field group keeps every status bit single-driven
	assign status = {bank_bits, cause_flags, alu_flags};

	// Option register, fully read/write
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			option_reg <= CSFR_OPTION_RST;
		end else if (wr_i.en && wr_i.addr == CSFR_OPTION_OFS) begin
			option_reg <= wr_i.data;
		end
	end

	// Upper program counter holding register, visible in either bank
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc_upper_holding_reg <= CSFR_PCHOLD_RST;
		end else if (wr_i.en && shared_hit(wr_i.addr, CSFR_PCHOLD_OFS_LO)) begin
			pc_upper_holding_reg <= wr_i.data[4:0];
		end
	end

	// PC upper bits are only ever a copy taken at a counter load
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc_upper_o <= 5'h00;
		end else if (pc_load_i) begin
			pc_upper_o <= pc_upper_holding_reg;
		end
	end

	// Bank decode from the direct bank select pair
	assign bank_o = status[CSFR_RP1_BIT:CSFR_RP0_BIT];
	assign bank_base_o = {bank_o, 7'h00};

	// Read port; status and holding register decode in both banks
	always_comb begin
		rd_data_o = 8'h00;
		rd_hit_o = 1'b0;
		if (shared_hit(rd_addr_i, CSFR_STATUS_OFS_LO)) begin
			rd_data_o = status;
			rd_hit_o = 1'b1;
		end else if (rd_addr_i == CSFR_OPTION_OFS) begin
			rd_data_o = option_reg;
			rd_hit_o = 1'b1;
		end else if (shared_hit(rd_addr_i, CSFR_PCHOLD_OFS_LO)) begin
			rd_data_o = {3'b000, pc_upper_holding_reg};
			rd_hit_o = 1'b1;
		end
	end

	assign option_o = option_reg;

	// Shared prescaler; rate field picks 2^(n+1) for timer, 2^n for watchdog
	always_comb begin
		presc_mask = '0;
		for (int i = 0; i < 8; i++) begin
			if (option_reg[CSFR_PSA_BIT]) begin
				presc_mask[i] = (i < int'(option_reg[2:0]));
			end else begin
				presc_mask[i] = (i <= int'(option_reg[2:0]));
			end
		end
	end

	// Only the assigned source advances the single prescaler
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			presc <= '0;
		end else if (option_reg[CSFR_PSA_BIT] ? wdt_tick_i : tmr_tick_i) begin
			presc <= presc + 1'b1;
		end
	end

	// Tick when all selected low prescaler bits are about to roll over
	assign presc_tick = ((presc & presc_mask) == presc_mask) &&
		(option_reg[CSFR_PSA_BIT] ? wdt_tick_i : tmr_tick_i);

	// Output pulses; the unassigned user bypasses the prescaler
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tmr_inc_o <= 1'b0;
			wdt_inc_o <= 1'b0;
		end else begin
			tmr_inc_o <= option_reg[CSFR_PSA_BIT] ? tmr_tick_i : presc_tick;
			wdt_inc_o <= option_reg[CSFR_PSA_BIT] ? presc_tick : wdt_tick_i;
		end
	end

	property p_flag_write_masked;
		@(posedge clk_i) disable iff (!rst_b_i)
		(flag_op && status_wr) |=> status[2:0] == {$past(next_z),
			$past(next_dc), $past(next_c)};
	endproperty
	a_flag_write_masked: assert property (p_flag_write_masked)
		else $error("status write reached a flag-updated bit");

	property p_reset_flags_protected;
		@(posedge clk_i) disable iff (!rst_b_i)
		(status_wr && !por_i && !wdt_clear_i && !sleep_i && !wdt_timeout_i)
		|=> $stable(status[4:3]);
	endproperty
	a_reset_flags_protected: assert property (p_reset_flags_protected)
		else $error("timeout or powerdown flag changed by a write");

	property p_bank_base;
		@(posedge clk_i) disable iff (!rst_b_i)
		status_wr |=> bank_base_o ==
			{$past(wr_i.data[CSFR_RP1_BIT:CSFR_RP0_BIT]), 7'h00};
	endproperty
	a_bank_base: assert property (p_bank_base)
		else $error("bank base does not match select bits");

	property p_sub_borrow;
		@(posedge clk_i) disable iff (!rst_b_i)
		(alu_i.op == CSFR_OP_SUB) |=>
			status[CSFR_C_BIT] == ($past(alu_i.a) >= $past(alu_i.b));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow)
		else $error("subtract carry is not an inverted borrow");

	property p_rotate_carry;
		@(posedge clk_i) disable iff (!rst_b_i)
		(alu_i.op == CSFR_OP_RLF) |=> status[CSFR_C_BIT] == $past(alu_i.a[7]);
	endproperty
	a_rotate_carry: assert property (p_rotate_carry)
		else $error("rotate left did not load carry from bit 7");

	property p_pc_copy;
		@(posedge clk_i) disable iff (!rst_b_i)
		pc_load_i |=> pc_upper_o == $past(pc_upper_holding_reg);
	endproperty
	a_pc_copy: assert property (p_pc_copy)
		else $error("pc upper bits not copied from holding register");

	property p_status_both_banks;
		@(posedge clk_i) disable iff (!rst_b_i)
		(rd_addr_i == CSFR_STATUS_OFS_HI) |-> rd_hit_o && rd_data_o == status;
	endproperty
	a_status_both_banks: assert property (p_status_both_banks)
		else $error("status not readable at the upper bank offset");

	property p_timer_direct;
		@(posedge clk_i) disable iff (!rst_b_i)
		(option_reg[CSFR_PSA_BIT] && tmr_tick_i) |=> tmr_inc_o;
	endproperty
	a_timer_direct: assert property (p_timer_direct)
		else $error("timer not clocked 1:1 under watchdog assignment");

	property p_sleep_flags;
		@(posedge clk_i) disable iff (!rst_b_i)
		(sleep_i && !por_i && !wdt_clear_i) |=>
			status[CSFR_TO_BIT] && !status[CSFR_PD_BIT];
	endproperty
	a_sleep_flags: assert property (p_sleep_flags)
		else $error("sleep did not set timeout and clear powerdown");

	property p_zero_flag;
		@(posedge clk_i) disable iff (!rst_b_i)
		(alu_i.op == CSFR_OP_LOGIC) |=>
			status[CSFR_Z_BIT] == ($past(alu_i.result) == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero flag does not follow the result");
endmodule // csfr_status

`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the CPU status flag register block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
$display("ERROR %0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import csfr_pkg::*;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	csfr_wr_t wr_i = '0;
	logic [8:0] rd_addr_i = '0;
	csfr_alu_t alu_i = '0;
	logic [6:0] ev = '0;
	logic [7:0] rd_data_o, option_o, tmr_cnt, wdt_cnt;
	logic rd_hit_o, tmr_inc_o, wdt_inc_o, chk_v = 1'b0;
	logic [4:0] pc_upper_o;
	logic [1:0] bank_o;
	logic [8:0] bank_base_o;
	logic [2:0] sel = '0;
	logic [15:0] obs, exp_now;
	logic [15:0] exp_q[$];
	logic [7:0] st, d;
	int error_cnt = 0, check_count = 0, cyc = 0;
	csfr_status #(.PRESC_W(8)) csfr_status_inst (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .wr_i(wr_i), .rd_addr_i(rd_addr_i),
		.rd_data_o(rd_data_o), .rd_hit_o(rd_hit_o), .alu_i(alu_i),
		.por_i(ev[6]), .wdt_clear_i(ev[5]), .sleep_i(ev[4]),
		.wdt_timeout_i(ev[3]), .pc_load_i(ev[2]), .pc_upper_o(pc_upper_o),
		.bank_o(bank_o), .bank_base_o(bank_base_o), .tmr_tick_i(ev[1]),
		.wdt_tick_i(ev[0]), .tmr_inc_o(tmr_inc_o), .wdt_inc_o(wdt_inc_o),
		.option_o(option_o));
	always #10 clk_i = ~clk_i;
	// Count prescaler pulses so ratios are judged over whole periods
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tmr_cnt <= '0;
			wdt_cnt <= '0;
		end else begin
			tmr_cnt <= tmr_cnt + tmr_inc_o;
			wdt_cnt <= wdt_cnt + wdt_inc_o;
		end
	end
	// Pick the output group that the current note refers to
	always_comb begin
		case (sel)
			3'd0: obs = {7'h00, rd_hit_o, rd_data_o};
			3'd1: obs = {5'h00, bank_o, bank_base_o};
			3'd2: obs = {11'h000, pc_upper_o};
			3'd3: obs = {8'h00, option_o};
			default: obs = {tmr_cnt, wdt_cnt};
		endcase
	end
	// Sampled mid-cycle, away from the edge that drives the inputs
	always @(negedge clk_i) begin
		if (chk_v) begin
			exp_now = exp_q.pop_front();
			`CHK(obs, exp_now)
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic rst();
		rst_b_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		st = CSFR_STATUS_RST;
	endtask
	task automatic chk(input logic [2:0] s, input logic [8:0] a,
			input logic [15:0] e);
		@(posedge clk_i);
		sel <= s;
		rd_addr_i <= a;
		chk_v <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk_i);
		chk_v <= 1'b0;
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk_i);
		wr_i <= '{1'b1, a, v};
		@(posedge clk_i);
		wr_i.en <= 1'b0;
	endtask
	task automatic pulse(input logic [6:0] m, input int n);
		repeat (n) begin
			@(posedge clk_i);
			ev <= m;
			@(posedge clk_i);
			ev <= '0;
		end
		repeat (3) @(posedge clk_i);
	endtask
	// Flag update with an optional colliding status write of 07h
	task automatic alu(input csfr_op_t op, input logic [7:0] a, b,
			input logic w);
		logic [8:0] s;
		logic [7:0] r;
		s = (op == CSFR_OP_SUB) ? a - b : a + b;
		r = (op == CSFR_OP_LOGIC) ? (a & b) : s[7:0];
		@(posedge clk_i);
		alu_i <= '{op, a, b, r};
		wr_i <= '{w, CSFR_STATUS_OFS_HI, 8'h07};
		@(posedge clk_i);
		alu_i.op <= CSFR_OP_NONE;
		wr_i.en <= 1'b0;
		case (op)
			CSFR_OP_ADD: st[2:0] = {r == 0, {1'b0, a[3:0]} + b[3:0] > 5'h0f, s[8]};
			CSFR_OP_SUB: st[2:0] = {r == 0, a[3:0] >= b[3:0], a >= b};
			CSFR_OP_LOGIC: st[2] = (r == 0);
			CSFR_OP_RLF: st[0] = a[7];
			default: st[0] = a[0];
		endcase
		if (w) st[7:5] = 3'b000;
		chk(0, CSFR_STATUS_OFS_LO, {8'h01, st});
	endtask
	logic [6:0] evm[7] = '{7'h10, 7'h08, 7'h18, 7'h20, 7'h10, 7'h40, 7'h28};
	logic [1:0] evx[7] = '{2'b10, 2'b00, 2'b10, 2'b11, 2'b10, 2'b11, 2'b11};
	initial begin
		void'($urandom(40));
		rst();
		chk(0, CSFR_STATUS_OFS_HI, 16'h0118);
		chk(0, 9'h085, 16'h0000);
		chk(0, 9'h103, 16'h0000);
		wr(9'h084, 8'hff);
		wr(CSFR_STATUS_OFS_LO, 8'h00);
		chk(0, CSFR_STATUS_OFS_HI, 16'h0118);
		wr(CSFR_STATUS_OFS_HI, 8'h27);
		chk(0, CSFR_STATUS_OFS_LO, 16'h013f);
		st = 8'hff;
		for (int b = 0; b < 4; b++) begin
			wr(b[0] ? CSFR_STATUS_OFS_HI : CSFR_STATUS_OFS_LO, {1'b0, b[1:0], 5'h1f});
			st = {1'b0, b[1:0], 5'h1f};
			chk(1, 9'h000, {5'h00, b[1:0], b[1:0], 7'h00});
			chk(0, b[0] ? CSFR_STATUS_OFS_LO : CSFR_STATUS_OFS_HI, {8'h01, st});
		end
		alu(CSFR_OP_SUB, 8'h10, 8'h10, 1'b1);
		alu(CSFR_OP_SUB, 8'h00, 8'h01, 1'b0);
		alu(CSFR_OP_ADD, 8'h0f, 8'hf1, 1'b1);
		repeat (40) begin
			alu(csfr_op_t'($urandom % 5 + 1), $urandom, $urandom, $urandom);
		end
		for (int i = 0; i < 7; i++) begin
			pulse(evm[i], 1);
			st[4:3] = evx[i];
			chk(0, CSFR_STATUS_OFS_LO, {8'h01, st});
		end
		wr(CSFR_PCHOLD_OFS_HI, 8'hf5);
		chk(0, CSFR_PCHOLD_OFS_LO, 16'h0115);
		chk(2, 9'h000, 16'h0000);
		pulse(7'h04, 1);
		chk(2, 9'h000, 16'h0015);
		d = $urandom;
		wr(CSFR_OPTION_OFS, d);
		chk(3, 9'h000, {8'h00, d});
		chk(0, CSFR_OPTION_OFS, {8'h01, d});
		rst();
		chk(0, CSFR_OPTION_OFS, 16'h01ff);
		chk(0, CSFR_STATUS_OFS_LO, 16'h0118);
		wr(CSFR_OPTION_OFS, 8'h01);
		pulse(7'h02, 16);
		pulse(7'h01, 3);
		chk(4, 9'h000, {8'd4, 8'd3});
		wr(CSFR_OPTION_OFS, 8'h08);
		pulse(7'h02, 5);
		pulse(7'h01, 2);
		chk(4, 9'h000, {8'd9, 8'd5});
		wr(CSFR_OPTION_OFS, 8'h09);
		pulse(7'h01, 4);
		pulse(7'h02, 2);
		chk(4, 9'h000, {8'd11, 8'd7});
		repeat (2) @(posedge clk_i);
		close_out();
	end
endmodule // tb_top
`default_nettype wire
